// file: dac_cal_device.sv
// Register access over APB is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
`include "dac_cal_consts.svh"

// Behaviour
// R1 - cal clock period 32 to 2048 clocks
// R2 - divider chosen by control bits 2:0
// R3 - host keeps cal clock 0.5-4 MHz
// R4 - separate cal engine per converter
// R5 - zero write to memctrl clears uncal flags
// R6 - cal clock runs only while enabled
// R7 - bits 4/5 select I/Q converter
// R8 - start bit begins cal, ~300 ticks
// R9 - status bits 6/7 show done
// R10 - host clears memctrl, then clock enable
// R11 - 32 coefficients readable and writable
// R12 - read bit presents coefficient in data
// R13 - host clears read bit between reads
// R14 - write bit stores data at address
// R15 - reference adjust two's complement six bits
// R16 - coarse gain six bits per converter
// R17 - fine gain six bits straight binary
// R18 - common-mode trim zero means disconnected
// R19 - all registers over serial port
// R20 - trim upper two bits read zero
module dac_cal_device #(
  parameter int unsigned CAL_CYCLES = `CAL_RUN_CYCLES
) (
  // clock and control
  input  wire logic       ref_clk_in,
  input  wire logic       srst_in,
  input  wire logic       ce_in,
  // serial register port
  spi_link_if.dev         link,
  // analog trims
  output logic      [5:0] i_fine_gain_out,
  output logic      [5:0] q_fine_gain_out,
  output logic      [5:0] i_coarse_gain_out,
  output logic      [5:0] q_coarse_gain_out,
  output logic      [5:0] i_cm_resistor_trim_out,
  output logic      [5:0] q_cm_resistor_trim_out,
  output logic      [5:0] reference_adjust_out,
  // calibration state
  output logic            cal_clk_out,
  output logic      [1:0] cal_busy_out
);

  // serial slave
  logic        sclk_q;
  logic [4:0]  bit_cnt;
  logic [15:0] rx_shift;
  logic [7:0]  tx_shift;
  logic        miso_q;
  logic        wr_strobe;
  logic [6:0]  wr_addr;
  logic [7:0]  wr_data;
  // registers
  logic [2:0]  cal_divider_select;
  logic        cal_clock_enable;
  logic [1:0]  cal_select;
  logic        coeff_mem_read;
  logic        coeff_mem_write;
  logic        cal_start;
  logic [4:0]  coeff_address;
  logic [5:0]  coeff_data;
  logic [1:0]  uncal_flag;
  logic [1:0]  cal_done;
  // calibration
  logic [11:0] div_cnt;
  logic [11:0] div_len;
  logic        cal_tick;
  logic [1:0]  done_set;
  logic [1:0]  run;
  logic [5:0]  rd_val [2];

  wire sclk_rise = ~link.cs_n & link.sclk & ~sclk_q;
  wire sclk_fall = ~link.cs_n & ~link.sclk & sclk_q;
  wire mem_clear = wr_strobe & (wr_addr == `REG_CAL_MEM_CONTROL) & (wr_data == `MEMCTRL_CLEAR_VALUE);
  wire coeff_wr  = wr_strobe & (wr_addr == `REG_COEFF_DATA) & coeff_mem_write;

  assign link.miso = miso_q;

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] read_reg(input logic [6:0] a);
    read_reg = 8'h00;
    case (a)
      `REG_I_FINE_GAIN:     read_reg = {2'b00, i_fine_gain_out}; // [R20]
      `REG_I_COARSE_GAIN:   read_reg = {2'b00, i_coarse_gain_out};
      `REG_I_CM_RESISTOR:   read_reg = {2'b00, i_cm_resistor_trim_out};
      `REG_Q_FINE_GAIN:     read_reg = {2'b00, q_fine_gain_out};
      `REG_Q_COARSE_GAIN:   read_reg = {2'b00, q_coarse_gain_out};
      `REG_Q_CM_RESISTOR:   read_reg = {2'b00, q_cm_resistor_trim_out};
      `REG_REF_ADJUST:      read_reg = {2'b00, reference_adjust_out};
      `REG_CAL_CONTROL:     read_reg = {2'b00, cal_select, cal_clock_enable, cal_divider_select};
      `REG_CAL_STATUS:      read_reg = {cal_done, 4'h0, uncal_flag}; // [R9]
      `REG_COEFF_ADDRESS:   read_reg = {3'b000, coeff_address};
      // the read bit swaps the held value for the selected memory word
      `REG_COEFF_DATA:      read_reg = {2'b00, coeff_mem_read ? (cal_select[0] ? rd_val[0] : rd_val[1])
                                                              : coeff_data}; // [R12]
      `REG_CAL_MEM_CONTROL: read_reg = {3'b000, cal_start, coeff_mem_write, coeff_mem_read, 2'b00};
      default:              read_reg = 8'h00;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // sclk is sampled on ref_clk, so it must stay well below half the clock rate
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      sclk_q    <= 1'b0;
      bit_cnt   <= 5'h00;
      rx_shift  <= 16'h0000;
      tx_shift  <= 8'h00;
      miso_q    <= 1'b0;
      wr_strobe <= 1'b0;
      wr_addr   <= 7'h00;
      wr_data   <= 8'h00;
    end else if (ce_in) begin
      sclk_q    <= link.sclk;
      wr_strobe <= 1'b0;
      if (link.cs_n) begin
        bit_cnt <= 5'h00;
      end else if (sclk_rise) begin
        rx_shift <= {rx_shift[14:0], link.mosi};
        bit_cnt  <= bit_cnt + 5'h01;
        if (bit_cnt == 5'h07 && rx_shift[6]) begin
          tx_shift <= read_reg({rx_shift[5:0], link.mosi}); // [R19]
        end
        if (bit_cnt == 5'h0F && !rx_shift[14]) begin
          wr_strobe <= 1'b1;
          wr_addr   <= rx_shift[13:7];
          wr_data   <= {rx_shift[6:0], link.mosi};
        end
      end else if (sclk_fall && bit_cnt >= 5'h08 && bit_cnt < `SPI_FRAME_BITS) begin
        miso_q   <= tx_shift[7];
        tx_shift <= {tx_shift[6:0], 1'b0};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      i_fine_gain_out        <= `TRIM_RESET;
      q_fine_gain_out        <= `TRIM_RESET;
      i_coarse_gain_out      <= `TRIM_RESET;
      q_coarse_gain_out      <= `TRIM_RESET;
      i_cm_resistor_trim_out <= `TRIM_RESET;
      q_cm_resistor_trim_out <= `TRIM_RESET;
      reference_adjust_out   <= `TRIM_RESET;
      cal_divider_select     <= 3'h0;
      cal_clock_enable       <= 1'b0;
      cal_select             <= 2'b00;
      coeff_address          <= 5'h00;
      coeff_data             <= 6'h00;
      coeff_mem_read         <= 1'b0;
      coeff_mem_write        <= 1'b0;
      cal_start              <= 1'b0;
    end else if (ce_in && wr_strobe) begin
      case (wr_addr)
        `REG_I_FINE_GAIN:     i_fine_gain_out        <= wr_data[5:0]; // [R17] [R20]
        `REG_Q_FINE_GAIN:     q_fine_gain_out        <= wr_data[5:0]; // [R17]
        `REG_I_COARSE_GAIN:   i_coarse_gain_out      <= wr_data[5:0]; // [R16]
        `REG_Q_COARSE_GAIN:   q_coarse_gain_out      <= wr_data[5:0]; // [R16]
        `REG_I_CM_RESISTOR:   i_cm_resistor_trim_out <= wr_data[5:0]; // [R18]
        `REG_Q_CM_RESISTOR:   q_cm_resistor_trim_out <= wr_data[5:0]; // [R18]
        `REG_REF_ADJUST:      reference_adjust_out   <= wr_data[5:0]; // [R15]
        `REG_CAL_CONTROL: begin
          cal_divider_select <= wr_data[`CTRL_DIV_SELECT_MSB:0]; // [R2]
          cal_clock_enable   <= wr_data[`CTRL_CLK_EN_BIT]; // [R6]
          cal_select         <= {wr_data[`CTRL_Q_SEL_BIT], wr_data[`CTRL_I_SEL_BIT]}; // [R7]
        end
        `REG_COEFF_ADDRESS:   coeff_address <= wr_data[4:0];
        `REG_COEFF_DATA:      coeff_data    <= wr_data[5:0];
        `REG_CAL_MEM_CONTROL: begin
          coeff_mem_read  <= wr_data[`MEMCTRL_READ_BIT]; // [R13]
          coeff_mem_write <= wr_data[`MEMCTRL_WRITE_BIT]; // [R14]
          cal_start       <= wr_data[`MEMCTRL_START_BIT]; // [R8]
        end
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // a completion in the same cycle as the clearing write survives
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      uncal_flag <= `UNCAL_RESET;
      cal_done   <= 2'b00;
    end else if (ce_in) begin
      uncal_flag <= uncal_flag & ~{2{mem_clear}}; // [R5]
      cal_done   <= done_set | (cal_done & ~{2{mem_clear}}); // [R9]
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // divide factor 32 << select, saturating at 2048
  assign div_len = (cal_divider_select >= `CAL_DIV_SELECT_LAST) ? `CAL_DIV_MAX
                                                            : (`CAL_DIV_MIN << cal_divider_select); // [R1]

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      div_cnt     <= 12'h000;
      cal_tick    <= 1'b0;
      cal_clk_out <= 1'b0;
    end else if (ce_in) begin
      if (!cal_clock_enable) begin
        div_cnt     <= 12'h000; // [R6]
        cal_tick    <= 1'b0;
        cal_clk_out <= 1'b0;
      end else begin
        div_cnt     <= (div_cnt == div_len - 12'h001) ? 12'h000 : div_cnt + 12'h001; // [R1]
        cal_tick    <= div_cnt == div_len - 12'h001;
        cal_clk_out <= div_cnt < (div_len >> 1);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // the engine sequences the run and stores a mid-scale code per coefficient;
  // the analog search itself lives outside this logic
  for (genvar g = 0; g < 2; g++) begin : gen_cal
    dac_cal_pkg::engine_state_t st;
    logic [8:0] ticks;
    logic [5:0] mem [`COEFF_COUNT];
    wire        last = cal_tick & (ticks == 9'(CAL_CYCLES - 1));

    always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
        st    <= dac_cal_pkg::E_IDLE;
        ticks <= 9'h000;
      end else if (ce_in) begin
        unique case (st)
          dac_cal_pkg::E_IDLE: begin
            if (cal_start && cal_select[g] && cal_clock_enable) begin // [R4] [R8]
              st    <= dac_cal_pkg::E_RUN;
              ticks <= 9'h000;
            end
          end
          dac_cal_pkg::E_RUN: begin
            if (!cal_start) begin
              st <= dac_cal_pkg::E_IDLE;
            end else if (cal_tick) begin
              ticks <= ticks + 9'h001;
              if (last) begin
                st <= dac_cal_pkg::E_DONE;
              end
            end
          end
          dac_cal_pkg::E_DONE: begin
            if (!cal_start) begin
              st <= dac_cal_pkg::E_IDLE;
            end
          end
          default: st <= dac_cal_pkg::E_IDLE;
        endcase
      end
    end

    always_ff @(posedge ref_clk_in) begin
      if (ce_in) begin
        if (st == dac_cal_pkg::E_RUN && cal_tick && ticks < 9'(`COEFF_COUNT)) begin
          mem[ticks[4:0]] <= `COEFF_NOMINAL;
        end else if (coeff_wr && cal_select[g]) begin
          mem[coeff_address] <= wr_data[5:0]; // [R11] [R14]
        end
      end
    end

    assign rd_val[g]   = mem[coeff_address]; // [R11]
    assign done_set[g] = (st == dac_cal_pkg::E_RUN) & cal_start & last; // [R9]
    assign run[g]      = st == dac_cal_pkg::E_RUN;
  end

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      cal_busy_out <= 2'b00;
    end else if (ce_in) begin
      cal_busy_out <= run;
    end
  end

endmodule

`default_nettype wire

// file: dac_cal_consts.svh
`ifndef DAC_CAL_CONSTS_SVH
`define DAC_CAL_CONSTS_SVH

////////////////////////////////////////////////////////////////////////////////
// device register offsets on the serial port
`define REG_I_FINE_GAIN     7'h03
`define REG_I_COARSE_GAIN   7'h04
`define REG_I_CM_RESISTOR   7'h05
`define REG_Q_FINE_GAIN     7'h06
`define REG_Q_COARSE_GAIN   7'h07
`define REG_Q_CM_RESISTOR   7'h08
`define REG_REF_ADJUST      7'h0D
`define REG_CAL_CONTROL     7'h0E
`define REG_CAL_STATUS      7'h0F
`define REG_COEFF_ADDRESS   7'h10
`define REG_COEFF_DATA      7'h11
`define REG_CAL_MEM_CONTROL 7'h12

////////////////////////////////////////////////////////////////////////////////
// field positions
`define CTRL_DIV_SELECT_MSB 2
`define CTRL_CLK_EN_BIT     3
`define CTRL_I_SEL_BIT      4
`define CTRL_Q_SEL_BIT      5
`define MEMCTRL_READ_BIT    2
`define MEMCTRL_WRITE_BIT   3
`define MEMCTRL_START_BIT   4
`define STATUS_I_UNCAL_BIT  0
`define STATUS_Q_UNCAL_BIT  1
`define STATUS_I_DONE_BIT   6
`define STATUS_Q_DONE_BIT   7
`define MEMCTRL_CLEAR_VALUE 8'h00

////////////////////////////////////////////////////////////////////////////////
// reset values and the mid-scale coefficient code
`define TRIM_RESET          6'h00
`define UNCAL_RESET         2'h3
`define COEFF_NOMINAL       6'h20

////////////////////////////////////////////////////////////////////////////////
// timing counts
`define CAL_DIV_MIN         12'h020
`define CAL_DIV_MAX         12'h800
`define CAL_DIV_SELECT_LAST 3'h6
`define CAL_RUN_CYCLES      300
`define COEFF_COUNT         32
`define SPI_FRAME_BITS      5'h10
`define SPI_HALF_CYCLES     4

////////////////////////////////////////////////////////////////////////////////
// host controller apb map
`define APB_CMD             12'h000
`define APB_STATUS          12'h004

`endif

// file: dac_cal_pkg.sv
`default_nettype none

package dac_cal_pkg;

  typedef enum logic [1:0] {
    H_IDLE  = 2'b00,
    H_LEAD  = 2'b01,
    H_SHIFT = 2'b11,
    H_TRAIL = 2'b10
  } host_state_t;

  typedef enum logic [1:0] {
    E_IDLE = 2'b00,
    E_RUN  = 2'b01,
    E_DONE = 2'b11
  } engine_state_t;

endpackage

`default_nettype wire

// file: spi_link_if.sv
`timescale 1ns/1ns
`default_nettype none

interface spi_link_if;
  logic cs_n;
  logic sclk;
  logic mosi;
  logic miso;

  modport host (output cs_n, output sclk, output mosi, input miso);
  modport dev  (input cs_n, input sclk, input mosi, output miso);
endinterface

`default_nettype wire

// file: dac_cal_host.sv
`timescale 1ns/1ns
`default_nettype none
`include "dac_cal_consts.svh"

module dac_cal_host #(
  parameter int unsigned HALF_PERIOD = `SPI_HALF_CYCLES
) (
  // clock and control
  input  wire logic        ref_clk_in,
  input  wire logic        srst_in,
  input  wire logic        ce_in,
  // apb slave
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [11:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  // serial register port
  spi_link_if.host         link
);

  dac_cal_pkg::host_state_t st;
  logic [15:0] cmd;
  logic [15:0] tx;
  logic [7:0]  rx;
  logic [4:0]  nbits;
  logic [7:0]  timer;
  logic        busy;
  logic        cs_n_q;
  logic        sclk_q;
  logic        mosi_q;
  logic [31:0] rd_word;
  logic        mapped;

  wire access   = psel_in & penable_in;
  wire half_end = timer == 8'(HALF_PERIOD - 1);
  // a command written while a frame runs is dropped; software polls busy first
  wire go       = access & pready_out & pwrite_in & (paddr_in == `APB_CMD) & ~busy; // [R19]

  assign link.cs_n = cs_n_q;
  assign link.sclk = sclk_q;
  assign link.mosi = mosi_q;

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    rd_word = 32'h0000_0000;
    mapped  = 1'b1;
    case (paddr_in)
      `APB_CMD:    rd_word = {16'h0000, cmd};
      `APB_STATUS: rd_word = {16'h0000, rx, 7'h00, busy};
      default:     mapped  = 1'b0;
    endcase
  end

  // one wait state: every access phase lasts two cycles
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      pready_out  <= 1'b0;
      prdata_out  <= 32'h0000_0000;
      pslverr_out <= 1'b0;
    end else if (ce_in) begin
      pready_out <= access & ~pready_out;
      if (access & ~pready_out) begin
        prdata_out  <= rd_word;
        pslverr_out <= ~mapped;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // frame: read flag, 7-bit address, 8 data bits, msb first
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      st     <= dac_cal_pkg::H_IDLE;
      cmd    <= 16'h0000;
      tx     <= 16'h0000;
      rx     <= 8'h00;
      nbits  <= 5'h00;
      timer  <= 8'h00;
      busy   <= 1'b0;
      cs_n_q <= 1'b1;
      sclk_q <= 1'b0;
      mosi_q <= 1'b0;
    end else if (ce_in) begin
      unique case (st)
        dac_cal_pkg::H_IDLE: begin
          if (go) begin
            cmd    <= pwdata_in[15:0];
            tx     <= {pwdata_in[14:0], 1'b0};
            mosi_q <= pwdata_in[15];
            cs_n_q <= 1'b0;
            busy   <= 1'b1;
            timer  <= 8'h00;
            nbits  <= 5'h00;
            st     <= dac_cal_pkg::H_LEAD;
          end
        end
        dac_cal_pkg::H_LEAD: begin
          timer <= half_end ? 8'h00 : timer + 8'h01;
          if (half_end) begin
            st <= dac_cal_pkg::H_SHIFT;
          end
        end
        dac_cal_pkg::H_SHIFT: begin
          timer <= half_end ? 8'h00 : timer + 8'h01;
          if (half_end) begin
            sclk_q <= ~sclk_q;
            if (!sclk_q) begin
              rx    <= {rx[6:0], link.miso};
              nbits <= nbits + 5'h01;
            end else if (nbits == `SPI_FRAME_BITS) begin
              st <= dac_cal_pkg::H_TRAIL;
            end else begin
              mosi_q <= tx[15];
              tx     <= {tx[14:0], 1'b0};
            end
          end
        end
        dac_cal_pkg::H_TRAIL: begin
          timer <= half_end ? 8'h00 : timer + 8'h01;
          if (half_end) begin
            cs_n_q <= 1'b1;
            busy   <= 1'b0;
            st     <= dac_cal_pkg::H_IDLE;
          end
        end
      endcase
    end
  end

endmodule

`default_nettype wire

// file: dac_cal_link_chk.sv
`timescale 1ns/1ns
`default_nettype none

module dac_cal_link_chk (
  // clock and reset
  input wire logic       ref_clk_in,
  input wire logic       srst_in,
  // serial link
  input wire logic       cs_n,
  input wire logic       sclk,
  input wire logic       mosi,
  // device outputs
  input wire logic [5:0] i_fine_gain_out,
  input wire logic [5:0] reference_adjust_out,
  input wire logic       cal_clk_out,
  input wire logic [1:0] cal_busy_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (srst_in);

  logic       sclk_q;
  logic [4:0] rises;

  ////////////////////////////////////////////////////////////////////////////////
  // counts sclk rises inside a frame, cleared between frames
  always_ff @(posedge ref_clk_in) begin
    sclk_q <= sclk;
  end

  always_ff @(posedge ref_clk_in) begin
    if (srst_in || cs_n) begin
      rises <= 5'h00;
    end else if (sclk && !sclk_q) begin
      rises <= rises + 5'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  sequence lead_s;
    !sclk [*4];
  endsequence

  sequence frame_s;
    ##[120:150] cs_n;
  endsequence

  idle_clock_a: assert property (cs_n |-> !sclk)
    else $error("sclk high outside a frame");
  frame_lead_a: assert property ($fell(cs_n) |-> lead_s)
    else $error("sclk rose before the lead time");
  clock_high_a: assert property ($rose(sclk) |-> sclk [*4] ##1 !sclk)
    else $error("sclk high phase not four cycles");
  mosi_hold_a: assert property (sclk |-> $stable(mosi))
    else $error("mosi moved while sclk high");
  frame_length_a: assert property ($fell(cs_n) |-> frame_s)
    else $error("frame length out of range");
  edge_count_a: assert property ($rose(cs_n) |-> rises == 5'h10)
    else $error("frame did not carry sixteen clocks");
  trim_quiet_a: assert property (cs_n |-> $stable(i_fine_gain_out) && $stable(reference_adjust_out))
    else $error("trim changed outside a frame");
  cal_half_a: assert property ($changed(cal_clk_out) && cal_busy_out != 2'b00 |=> $stable(cal_clk_out) [*8])
    else $error("calibration clock phase too short");
endmodule

`default_nettype wire

// file: dac_self_cal_and_gain_trim_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "dac_cal_consts.svh"
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin failures++; \
  $display("[FAIL] %s exp %h got %h", nm, e, g); end end

module dac_self_cal_and_gain_trim_tb;
  logic        ref_clk_in = 1'b0;
  logic        srst_in    = 1'b1;
  logic        psel       = 1'b0;
  logic        penable    = 1'b0;
  logic        pwrite     = 1'b0;
  logic [11:0] paddr      = 12'h000;
  logic [31:0] pwdata     = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [5:0]  trim [7];
  logic        cal_clk;
  logic [1:0]  busy;
  int          failures   = 0;
  int          compares   = 0;
  int          cycles     = 0;
  logic [31:0] seed       = 32'h0000_4C9D;
  logic [6:0]  taddr [7]  = '{`REG_I_FINE_GAIN, `REG_I_COARSE_GAIN, `REG_I_CM_RESISTOR, `REG_Q_FINE_GAIN,
                              `REG_Q_COARSE_GAIN, `REG_Q_CM_RESISTOR, `REG_REF_ADJUST};

  spi_link_if link ();

  always #5 ref_clk_in = ~ref_clk_in;

  dac_cal_host #(.HALF_PERIOD(4)) dac_cal_host_inst (.ref_clk_in(ref_clk_in), .srst_in(srst_in), .ce_in(1'b1),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .link(link));

  dac_cal_device #(.CAL_CYCLES(40)) dac_cal_device_inst (.ref_clk_in(ref_clk_in), .srst_in(srst_in), .ce_in(1'b1),
    .link(link), .i_fine_gain_out(trim[0]), .i_coarse_gain_out(trim[1]), .i_cm_resistor_trim_out(trim[2]),
    .q_fine_gain_out(trim[3]), .q_coarse_gain_out(trim[4]), .q_cm_resistor_trim_out(trim[5]),
    .reference_adjust_out(trim[6]), .cal_clk_out(cal_clk), .cal_busy_out(busy));

  dac_cal_link_chk dac_cal_link_chk_inst (.ref_clk_in(ref_clk_in), .srst_in(srst_in), .cs_n(link.cs_n),
    .sclk(link.sclk), .mosi(link.mosi), .i_fine_gain_out(trim[0]), .reference_adjust_out(trim[6]),
    .cal_clk_out(cal_clk), .cal_busy_out(busy));

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // selects above 6 saturate at the longest division
  function automatic int div_period(input int n);
    return 32 << ((n > 6) ? 6 : n);
  endfunction

  task automatic finish_test();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  always @(posedge ref_clk_in) begin
    cycles++;
    if (cycles == 90000) begin
      failures++;
      finish_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    @(posedge ref_clk_in);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge ref_clk_in);
    penable <= 1'b1;
    // only the bench timeout ends this wait
    do begin
      @(posedge ref_clk_in);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // one device frame, then poll until the host is idle again
  task automatic xfer(input logic rw, input logic [6:0] a, input logic [7:0] d, output logic [7:0] q);
    logic [31:0] r;
    logic        e;
    int          n;
    apb(1'b1, `APB_CMD, {16'h0000, rw, a, d}, r, e);
    n = 0;
    do begin
      apb(1'b0, `APB_STATUS, 32'h0000_0000, r, e);
      n++;
    end while (r[0] !== 1'b0 && n < 100);
    q = r[15:8];
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] q;
    xfer(1'b0, a, d, q);
  endtask

  task automatic rd(input logic [6:0] a, output logic [7:0] q);
    xfer(1'b1, a, 8'h00, q);
  endtask

  task automatic coeff_rd(input logic [4:0] a, output logic [7:0] q);
    wr(`REG_COEFF_ADDRESS, {3'b000, a});
    wr(`REG_CAL_MEM_CONTROL, 8'h04);
    rd(`REG_COEFF_DATA, q);
    wr(`REG_CAL_MEM_CONTROL, `MEMCTRL_CLEAR_VALUE);
  endtask

  task automatic period(output int p);
    int   r;
    int   n;
    logic pv;
    r = 0;
    p = 0;
    n = 0;
    pv = cal_clk;
    while (r < 2 && n < 5000) begin
      @(posedge ref_clk_in);
      n++;
      if (r == 1) p++;
      if (cal_clk === 1'b1 && pv === 1'b0) r++;
      pv = cal_clk;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0]  q;
    logic [7:0]  d;
    logic [31:0] r;
    logic        e;
    logic [5:0]  qm [32];
    int          p;
    repeat (12) @(posedge ref_clk_in);
    srst_in <= 1'b0;
    @(posedge ref_clk_in);
    for (int k = 0; k < 7; k++) `CHK("trim reset", 6'h00, trim[k])
    rd(`REG_CAL_STATUS, q);
    `CHK("status reset", 8'h03, q)
    apb(1'b0, 12'h008, 32'h0000_0000, r, e);
    `CHK("unmapped slverr", 1'b1, e)
    // extreme two's complement codes first, with upper bit 6 set in both and bit 7 in the first
    for (int j = 0; j < 3; j++) begin
      for (int k = 0; k < 7; k++) begin
        r = xs();
        d = (j == 0) ? 8'hDF : (j == 1) ? 8'h60 : r[7:0];
        wr(taddr[k], d);
        `CHK("trim out", d[5:0], trim[k])
        rd(taddr[k], q);
        `CHK("trim read", {2'b00, d[5:0]}, q)
      end
    end
    // longest first, so the stop check below starts from a fast clock
    for (int k = 7; k >= 0; k--) begin
      wr(`REG_CAL_CONTROL, 8'h08 | k[7:0]);
      period(p);
      period(p);
      `CHK("cal period", div_period(k), p)
    end
    wr(`REG_CAL_CONTROL, 8'h00);
    p = 0;
    repeat (600) begin
      @(posedge ref_clk_in);
      if (cal_clk !== 1'b0) p++;
    end
    `CHK("cal clock stopped", 0, p)
    wr(`REG_CAL_MEM_CONTROL, `MEMCTRL_CLEAR_VALUE);
    rd(`REG_CAL_STATUS, q);
    `CHK("uncal cleared", 8'h00, q)
    wr(`REG_CAL_CONTROL, 8'h18);
    wr(`REG_CAL_MEM_CONTROL, 8'h10);
    `CHK("i engine only", 2'b01, busy)
    p = 0;
    do begin
      rd(`REG_CAL_STATUS, q);
      p++;
    end while (q[6] !== 1'b1 && p < 50);
    `CHK("i done only", 8'h40, q)
    wr(`REG_CAL_MEM_CONTROL, `MEMCTRL_CLEAR_VALUE);
    wr(`REG_CAL_CONTROL, 8'h10);
    for (int a = 0; a < 32; a++) begin
      coeff_rd(a[4:0], q);
      `CHK("i coeff", 8'h20, q)
    end
    wr(`REG_CAL_CONTROL, 8'h20);
    wr(`REG_CAL_MEM_CONTROL, 8'h08);
    for (int a = 0; a < 32; a++) begin
      r = xs();
      qm[a] = (a == 0) ? 6'h3F : (a == 31) ? 6'h00 : r[5:0];
      wr(`REG_COEFF_ADDRESS, a[7:0]);
      wr(`REG_COEFF_DATA, {2'b00, qm[a]});
    end
    wr(`REG_CAL_MEM_CONTROL, `MEMCTRL_CLEAR_VALUE);
    for (int a = 0; a < 32; a++) begin
      coeff_rd(a[4:0], q);
      `CHK("q coeff", {2'b00, qm[a]}, q)
    end
    wr(`REG_CAL_CONTROL, 8'h10);
    coeff_rd(5'h09, q);
    `CHK("i coeff kept", 8'h20, q)
    // both engines in one run, then the clearing write drops both done bits
    wr(`REG_CAL_CONTROL, 8'h38);
    wr(`REG_CAL_MEM_CONTROL, 8'h10);
    `CHK("both engines", 2'b11, busy)
    p = 0;
    do begin
      rd(`REG_CAL_STATUS, q);
      p++;
    end while (q[7:6] !== 2'b11 && p < 50);
    `CHK("both done", 8'hC0, q)
    wr(`REG_CAL_MEM_CONTROL, `MEMCTRL_CLEAR_VALUE);
    rd(`REG_CAL_STATUS, q);
    `CHK("done cleared", 8'h00, q)
    finish_test();
  end
endmodule

`default_nettype wire
